// ### aisd_coupler.sv
`timescale 1ns/10ps

module aisd_coupler (
   input wire logic clk_i,
   input wire logic rec_valid_i,
   input wire logic rec_err_i,
   input wire aisd_pkg::aisd_byte_t rec_data_i,
   input wire logic [4:0] rec_len_i,
   output logic rec_req_o,
   output logic rec_write_o,
   output aisd_pkg::aisd_path_t rec_path_o,
   output logic [15:0] rec_key_o,
   output logic [7:0] rec_sub_o,
   output logic [4:0] rec_byte_o,
   output logic [7:0] rec_wdata_o
);
   import aisd_pkg::*;

   // ************************************************************
   // record reader and writer
   // ************************************************************
   initial begin
      rec_req_o = 1'b0;
      rec_write_o = 1'b0;
      rec_path_o = AISD_PATH_NONE;
      rec_key_o = 16'h0000;
      rec_sub_o = 8'h00;
      rec_byte_o = 5'h00;
      rec_wdata_o = 8'h00;
   end

   // one-cycle request, answer taken at the following edge
   task automatic xfer(input logic wr, input aisd_path_t p, input logic [15:0] k,
         input logic [7:0] s, input logic [4:0] b, input logic [7:0] wd, output logic v,
         output logic e, output logic [7:0] d, output logic [4:0] l);
      @(posedge clk_i);
      rec_req_o <= 1'b1;
      rec_write_o <= wr;
      rec_path_o <= p;
      rec_key_o <= k;
      rec_sub_o <= s;
      rec_byte_o <= b;
      rec_wdata_o <= wd;
      @(posedge clk_i);
      rec_req_o <= 1'b0;
      rec_key_o <= ~k;
      rec_sub_o <= ~s;
      rec_byte_o <= ~b;
      rec_wdata_o <= ~wd;
      // answer stands for the cycle after the taking edge; read it settled
      #1;
      v = rec_valid_i;
      e = rec_err_i;
      d = rec_data_i;
      l = rec_len_i;
   endtask : xfer
endmodule : aisd_coupler

// ### aisd_defs.svh
`ifndef AISD_DEFS_SVH
`define AISD_DEFS_SVH

// ************************************************************
// timing
// ************************************************************
`define AISD_CLK_PERIOD_NS 100
`define AISD_US_NS 1000
`define AISD_US_CYCLES (`AISD_US_NS / `AISD_CLK_PERIOD_NS)

// ************************************************************
// function numbers
// ************************************************************
`define AISD_FN_OFF 8'hFF
`define AISD_FN_BI_27648 8'h12
`define AISD_FN_UNI_27648 8'h10
`define AISD_FN_BI_16384 8'h22
`define AISD_FN_UNI_16384 8'h20
`define AISD_FN_RESET 8'h12

// ************************************************************
// scaling
// ************************************************************
`define AISD_NOM_27648 32'sh00006C00
`define AISD_NOM_16384 32'sh00004000
`define AISD_FULL_MV 32'sh00002710
`define AISD_HI_27648 16'h7EFF
`define AISD_LO_BI_27648 16'h8100
`define AISD_LO_UNI_27648 16'hED00
`define AISD_HI_16384 16'h5000
`define AISD_LO_BI_16384 16'hB000
`define AISD_LO_UNI_16384 16'hF333

// ************************************************************
// diagnostic bytes
// ************************************************************
`define AISD_SUM_MOD_FAIL 0
`define AISD_SUM_INTERNAL 1
`define AISD_SUM_EXTERNAL 2
`define AISD_SUM_CHANNEL 3
`define AISD_SUM_AUX 4
`define AISD_SUM_PARAM 7
`define AISD_INT_COMM 4
`define AISD_CH_CFG 0
`define AISD_CH_UNDER 6
`define AISD_CH_OVER 7
`define AISD_MODULE_INFO 8'h15
`define AISD_CHANNEL_KIND 8'h71
`define AISD_BITS_PER_CH 8'h08
`define AISD_CHANNEL_COUNT 8'h04
`define AISD_RESERVED_BYTE 8'h00

// ************************************************************
// record access keys
// ************************************************************
`define AISD_RS_SHORT 16'h0000
`define AISD_RS_FULL 16'h0001
`define AISD_RS_FN_BASE 16'h0080
`define AISD_IX_SHORT 16'h2F00
`define AISD_IX_FULL 16'h2F01
`define AISD_IX_FN_BASE 16'h3100
`define AISD_SX_INDEX 16'h5005
`define AISD_SX_FIRST 8'h02
`define AISD_SX_LAST_BYTE 8'h11
`define AISD_SX_STAMP 8'h13
`define AISD_LEN_FULL 5'h14
`define AISD_LEN_SHORT 5'h04
`define AISD_LEN_STAMP 5'h04
`define AISD_LEN_ONE 5'h01
`define AISD_STAMP_BYTE 5'h10

`endif

// ### aisd_diag_properties.sv
`timescale 1ns/10ps
`include "aisd_defs.svh"

module aisd_diag_properties (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic adc_valid_i,
   input wire logic rec_req_i,
   input wire logic rec_write_i,
   input wire aisd_pkg::aisd_path_t rec_path_i,
   input wire logic [15:0] rec_key_i,
   input wire logic [7:0] rec_sub_i,
   input wire logic [4:0] rec_byte_i,
   input wire logic rec_valid_o,
   input wire logic rec_err_o,
   input wire aisd_pkg::aisd_byte_t rec_data_o,
   input wire logic [4:0] rec_len_o,
   input wire logic [3:0][15:0] chan_value_o,
   input wire logic [3:0] chan_led_o,
   input wire logic mod_led_o
);
   import aisd_pkg::*;

   // ************************************************************
   // record port and sample port checks
   // ************************************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_rd(p, k, lim);
      rec_req_i && !rec_write_i && rec_path_i == p && rec_key_i == k && rec_byte_i < lim;
   endsequence

   sequence s_ok(n);
      rec_valid_o && !rec_err_o && rec_len_o == n;
   endsequence

   a_answer_next:
   assert property (rec_req_i |=> rec_valid_o) else $error("request not answered");
   a_no_unasked:
   assert property (!rec_req_i |=> !rec_valid_o) else $error("answer without request");
   a_refuse_none:
   assert property (rec_req_i && rec_path_i == AISD_PATH_NONE |=> rec_err_o && rec_len_o == 5'h00)
      else $error("path none not refused");
   a_full_len:
   assert property (s_rd(AISD_PATH_RECORD_SET, `AISD_RS_FULL, 5'h14) |=> s_ok(`AISD_LEN_FULL))
      else $error("full record answer wrong");
   a_short_len:
   assert property (s_rd(AISD_PATH_RECORD_SET, `AISD_RS_SHORT, 5'h04) |=> s_ok(`AISD_LEN_SHORT))
      else $error("short record answer wrong");
   a_dict_info:
   assert property (s_rd(AISD_PATH_DICT_INDEX, `AISD_IX_SHORT, 5'h04) ##0 rec_byte_i == 5'h01
      |=> s_ok(`AISD_LEN_SHORT) ##0 rec_data_o == `AISD_MODULE_INFO)
      else $error("module info by index wrong");
   a_stamp_len:
   assert property (s_rd(AISD_PATH_SUBINDEX, `AISD_SX_INDEX, 5'h04) ##0 rec_sub_i == `AISD_SX_STAMP
      |=> s_ok(`AISD_LEN_STAMP)) else $error("timestamp subindex answer wrong");
   a_value_hold:
   assert property (!adc_valid_i |=> $stable(chan_value_o)) else $error("value moved without sample");
   a_reset_quiet:
   assert property (disable iff (1'b0) !rst_b_i |=> !rec_valid_o && !mod_led_o && chan_led_o == 4'h0)
      else $error("outputs not clear in reset");
   for (genvar i = 0; i < 4; i++) begin : g_ch
      a_value_range:
      assert property ($signed(chan_value_o[i]) <= 16'sh7EFF
         && $signed(chan_value_o[i]) >= -16'sh7F00) else $error("value beyond limit codes");
   end
endmodule : aisd_diag_properties

bind aisd_diag_top aisd_diag_properties u_props (.clk_i, .rst_b_i, .adc_valid_i, .rec_req_i,
   .rec_write_i, .rec_path_i, .rec_key_i, .rec_sub_i, .rec_byte_i, .rec_valid_o, .rec_err_o,
   .rec_data_o, .rec_len_o, .chan_value_o, .chan_led_o, .mod_led_o);

// ### aisd_diag_top.sv
`timescale 1ns/10ps
`include "aisd_defs.svh"

// Notes on behaviour
// - function number FFh switches a channel off; it is then not measured
// - codes 12h and 10h report D = 27648 x U / 10
// - 27648 formats clamp at 32511 high, -32512 bipolar, -4864 unipolar low
// - codes 22h and 20h report D = 16384 x U / 10
// - 16384 formats clamp at 20480 high, -20480 bipolar, -3277 unipolar low
// - a channel error lights that channel's indicator and enters the record
// - no diagnostic interrupt; diagnostics only through reading the record
// - error kinds: configuration, range overflow and range underflow
// - record set 01h gives the whole record, 00h its first 4 bytes
// - dictionary index 2F01h gives the whole record, 2F00h the first 4
// - index 5005h subindices 02h to 11h map record bytes 0 to 15, 13h the timestamp
// - summary byte bits 0 to 4 flag failure, internal, external, channel, supply
// - summary bit 7 flags a parameterization error
// - module info holds class 0101b and channel info bit 4
// - fixed descriptors 15h, 71h, 08h, 04h; error bytes reset to 00h
// - four channel error bytes, four zero bytes, then 4-byte timestamp
// - channel byte: bit 0 configuration, bit 6 underflow, bit 7 overflow
// - channel summary bit n marks an error on channel n
// - 32-bit microsecond counter from zero at reset, wrapping
// - a new diagnostic event stores the microsecond counter value

module aisd_diag_top (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic adc_valid_i,
   input wire logic [1:0] adc_ch_i,
   input wire logic signed [15:0] adc_mv_i,
   input wire logic module_fail_i,
   input wire logic aux_missing_i,
   input wire logic comm_err_i,
   input wire logic rec_req_i,
   input wire logic rec_write_i,
   input wire aisd_pkg::aisd_path_t rec_path_i,
   input wire logic [15:0] rec_key_i,
   input wire logic [7:0] rec_sub_i,
   input wire logic [4:0] rec_byte_i,
   input wire logic [7:0] rec_wdata_i,
   output logic rec_valid_o,
   output logic rec_err_o,
   output aisd_pkg::aisd_byte_t rec_data_o,
   output logic [4:0] rec_len_o,
   output logic [3:0][15:0] chan_value_o,
   output logic [3:0] chan_led_o,
   output logic mod_led_o
);
   import aisd_pkg::*;

   localparam int unsigned US_LAST = `AISD_US_CYCLES - 1;

   logic [7:0] fn_q [4];
   logic [3:0] over_q;
   logic [3:0] under_q;
   logic [3:0] cfg_err;
   logic [3:0] fn_wr;
   logic [7:0] chan_err [4];
   logic [7:0] chan_sum;
   logic [7:0] diag_sum;
   logic [7:0] int_faults;
   logic [39:0] diag_now;
   logic [39:0] diag_prev_q;
   logic diag_event;
   logic [3:0] pre_q;
   logic [31:0] us_q;
   logic [31:0] stamp_q;
   logic [7:0] sc_fn;
   aisd_word_t sc_code;
   logic sc_over;
   logic sc_under;
   logic sc_active;
   logic sc_cfg_err;
   logic [7:0] cfg_fn [4];
   logic [7:0] cfg_unused_fn;
   logic hit;
   logic is_fn;
   logic [1:0] fn_sel;
   logic [4:0] idx;
   logic [4:0] len;
   logic [7:0] rbyte;

   // ************************************************************
   // scaling of the incoming sample
   // ************************************************************
   assign sc_fn = fn_q[adc_ch_i];

   aisd_scaler u_scaler (
      .fn_i(sc_fn),
      .mv_i(adc_mv_i),
      .code_o(sc_code),
      .over_o(sc_over),
      .under_o(sc_under),
      .active_o(sc_active),
      .cfg_err_o(sc_cfg_err)
   );

   // ************************************************************
   // per channel state
   // ************************************************************
   generate
      for (genvar i = 0; i < 4; i++) begin : g_ch
         logic sample_hit;

         assign sample_hit = adc_valid_i && (adc_ch_i == 2'(i));

         // function number, written over the record port
         always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
               fn_q[i] <= `AISD_FN_RESET;
            end else if (fn_wr[i]) begin
               fn_q[i] <= rec_wdata_i;
            end
         end

         // configuration check of the stored function number
         aisd_scaler u_cfg (
            .fn_i(fn_q[i]),
            .mv_i(16'h0000),
            .code_o(),
            .over_o(),
            .under_o(),
            .active_o(),
            .cfg_err_o(cfg_err[i])
         );

         // converted value and range flags
         always_ff @(posedge clk_i) begin
            if (!rst_b_i) begin
               chan_value_o[i] <= 16'h0000;
               over_q[i] <= 1'b0;
               under_q[i] <= 1'b0;
            end else if (fn_q[i] == `AISD_FN_OFF || cfg_err[i]) begin
               over_q[i] <= 1'b0;
               under_q[i] <= 1'b0;
            end else if (sample_hit && sc_active) begin
               chan_value_o[i] <= sc_code;
               over_q[i] <= sc_over;
               under_q[i] <= sc_under;
            end
         end

         // channel specific error byte
         always_comb begin
            chan_err[i] = 8'h00;
            chan_err[i][`AISD_CH_CFG] = cfg_err[i];
            chan_err[i][`AISD_CH_UNDER] = under_q[i];
            chan_err[i][`AISD_CH_OVER] = over_q[i];
         end

         assign chan_sum[i] = |chan_err[i];
         assign chan_sum[i + 4] = 1'b0;
         assign cfg_fn[i] = fn_q[i];
      end
   endgenerate

   assign cfg_unused_fn = cfg_fn[0];

   // ************************************************************
   // module summary bytes
   // ************************************************************
   always_comb begin
      int_faults = 8'h00;
      int_faults[`AISD_INT_COMM] = comm_err_i;
      diag_sum = 8'h00;
      diag_sum[`AISD_SUM_MOD_FAIL] = module_fail_i;
      diag_sum[`AISD_SUM_INTERNAL] = |int_faults;
      diag_sum[`AISD_SUM_EXTERNAL] = |(over_q | under_q);
      diag_sum[`AISD_SUM_CHANNEL] = |chan_sum;
      diag_sum[`AISD_SUM_AUX] = aux_missing_i;
      diag_sum[`AISD_SUM_PARAM] = |cfg_err;
   end

   // ************************************************************
   // indicators
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         chan_led_o <= 4'h0;
         mod_led_o <= 1'b0;
      end else begin
         chan_led_o <= chan_sum[3:0];
         mod_led_o <= |diag_sum;
      end
   end

   // ************************************************************
   // microsecond ticker
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pre_q <= 4'h0;
         us_q <= 32'h00000000;
      end else if (32'(pre_q) == US_LAST) begin
         pre_q <= 4'h0;
         us_q <= us_q + 32'h00000001;
      end else begin
         pre_q <= pre_q + 4'h1;
      end
   end

   // ************************************************************
   // diagnostic event capture
   // ************************************************************
   assign diag_now = {chan_err[3], chan_err[2], chan_err[1], chan_err[0], diag_sum};
   assign diag_event = |(diag_now & ~diag_prev_q);

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         diag_prev_q <= 40'h0000000000;
      end else begin
         diag_prev_q <= diag_now;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         stamp_q <= 32'h00000000;
      end else if (diag_event) begin
         stamp_q <= us_q;
      end
   end

   // ************************************************************
   // record request decode
   // ************************************************************
   always_comb begin
      hit = 1'b0;
      is_fn = 1'b0;
      fn_sel = rec_key_i[1:0];
      idx = rec_byte_i;
      len = `AISD_LEN_FULL;
      case (rec_path_i)
         AISD_PATH_RECORD_SET: begin
            if (rec_key_i == `AISD_RS_FULL) begin
               hit = rec_byte_i < `AISD_LEN_FULL;
            end else if (rec_key_i == `AISD_RS_SHORT) begin
               len = `AISD_LEN_SHORT;
               hit = rec_byte_i < `AISD_LEN_SHORT;
            end else if (rec_key_i[15:2] == 14'(`AISD_RS_FN_BASE >> 2)) begin
               is_fn = 1'b1;
               len = `AISD_LEN_ONE;
               hit = rec_byte_i == 5'h00;
            end
         end
         AISD_PATH_DICT_INDEX: begin
            if (rec_key_i == `AISD_IX_FULL) begin
               hit = rec_byte_i < `AISD_LEN_FULL;
            end else if (rec_key_i == `AISD_IX_SHORT) begin
               len = `AISD_LEN_SHORT;
               hit = rec_byte_i < `AISD_LEN_SHORT;
            end else if (rec_key_i[15:2] == 14'(`AISD_IX_FN_BASE >> 2)) begin
               is_fn = 1'b1;
               len = `AISD_LEN_ONE;
               hit = rec_byte_i == 5'h00;
            end
         end
         AISD_PATH_SUBINDEX: begin
            if (rec_key_i == `AISD_SX_INDEX) begin
               if (rec_sub_i >= `AISD_SX_FIRST && rec_sub_i <= `AISD_SX_LAST_BYTE) begin
                  len = `AISD_LEN_ONE;
                  idx = 5'(rec_sub_i - `AISD_SX_FIRST);
                  hit = rec_byte_i == 5'h00;
               end else if (rec_sub_i == `AISD_SX_STAMP) begin
                  len = `AISD_LEN_STAMP;
                  idx = `AISD_STAMP_BYTE + 5'(rec_byte_i[1:0]);
                  hit = rec_byte_i < `AISD_LEN_STAMP;
               end
            end
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      if (rec_write_i && !is_fn) begin
         hit = 1'b0;
      end
   end

   assign fn_wr = (rec_req_i && rec_write_i && hit) ? (4'h1 << fn_sel) : 4'h0;

   // ************************************************************
   // record byte layout
   // ************************************************************
   always_comb begin
      rbyte = `AISD_RESERVED_BYTE;
      case (idx)
         5'h00: rbyte = diag_sum;
         5'h01: rbyte = `AISD_MODULE_INFO;
         5'h02: rbyte = `AISD_RESERVED_BYTE;
         5'h03: rbyte = int_faults;
         5'h04: rbyte = `AISD_CHANNEL_KIND;
         5'h05: rbyte = `AISD_BITS_PER_CH;
         5'h06: rbyte = `AISD_CHANNEL_COUNT;
         5'h07: rbyte = chan_sum;
         5'h08: rbyte = chan_err[0];
         5'h09: rbyte = chan_err[1];
         5'h0A: rbyte = chan_err[2];
         5'h0B: rbyte = chan_err[3];
         5'h10: rbyte = stamp_q[7:0];
         5'h11: rbyte = stamp_q[15:8];
         5'h12: rbyte = stamp_q[23:16];
         5'h13: rbyte = stamp_q[31:24];
         default: rbyte = `AISD_RESERVED_BYTE;
      endcase
      if (is_fn) begin
         rbyte = fn_q[fn_sel];
      end
   end

   // ************************************************************
   // record answer, polled only
   // ************************************************************
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         rec_valid_o <= 1'b0;
         rec_err_o <= 1'b0;
         rec_data_o <= 8'h00;
         rec_len_o <= 5'h00;
      end else begin
         rec_valid_o <= rec_req_i;
         rec_err_o <= rec_req_i && !hit;
         if (rec_req_i) begin
            rec_data_o <= (hit && !rec_write_i) ? rbyte : 8'h00;
            rec_len_o <= hit ? len : 5'h00;
         end
      end
   end

endmodule : aisd_diag_top

// ### aisd_pkg.sv
package aisd_pkg;

   // ************************************************************
   // access paths of the record port
   // ************************************************************
   typedef enum logic [1:0] {
      AISD_PATH_RECORD_SET,
      AISD_PATH_DICT_INDEX,
      AISD_PATH_SUBINDEX,
      AISD_PATH_NONE
   } aisd_path_t;

   typedef logic [7:0] aisd_byte_t;
   typedef logic signed [15:0] aisd_word_t;

endpackage : aisd_pkg

// ### aisd_scaler.sv
`timescale 1ns/10ps
`include "aisd_defs.svh"

module aisd_scaler (
   input wire logic [7:0] fn_i,
   input wire logic signed [15:0] mv_i,
   output aisd_pkg::aisd_word_t code_o,
   output logic over_o,
   output logic under_o,
   output logic active_o,
   output logic cfg_err_o
);
   import aisd_pkg::*;

   logic signed [31:0] nom;
   logic signed [31:0] hi;
   logic signed [31:0] lo;
   logic signed [31:0] prod;
   logic signed [31:0] scaled;

   // ************************************************************
   // format select
   // ************************************************************
   always_comb begin
      nom = `AISD_NOM_27648;
      hi = 32'(signed'(`AISD_HI_27648));
      lo = 32'(signed'(`AISD_LO_BI_27648));
      active_o = 1'b1;
      cfg_err_o = 1'b0;
      case (fn_i)
         `AISD_FN_BI_27648: begin
            nom = `AISD_NOM_27648;
         end
         `AISD_FN_UNI_27648: begin
            lo = 32'(signed'(`AISD_LO_UNI_27648));
         end
         `AISD_FN_BI_16384: begin
            nom = `AISD_NOM_16384;
            hi = 32'(signed'(`AISD_HI_16384));
            lo = 32'(signed'(`AISD_LO_BI_16384));
         end
         `AISD_FN_UNI_16384: begin
            nom = `AISD_NOM_16384;
            hi = 32'(signed'(`AISD_HI_16384));
            lo = 32'(signed'(`AISD_LO_UNI_16384));
         end
         `AISD_FN_OFF: begin
            active_o = 1'b0;
         end
         default: begin
            active_o = 1'b0;
            cfg_err_o = 1'b1;
         end
      endcase
   end

   // ************************************************************
   // scale and clamp
   // ************************************************************
   always_comb begin
      prod = 32'(mv_i) * nom;
      scaled = prod / `AISD_FULL_MV;
      over_o = 1'b0;
      under_o = 1'b0;
      code_o = scaled[15:0];
      if (scaled > hi) begin
         over_o = 1'b1;
         code_o = hi[15:0];
      end else if (scaled < lo) begin
         under_o = 1'b1;
         code_o = lo[15:0];
      end
   end

endmodule : aisd_scaler

// ### tb_top.sv
`timescale 1ns/10ps
`include "aisd_defs.svh"

module tb_top;
   import aisd_pkg::*;

   // ************************************************************
   // bench
   // ************************************************************
   localparam aisd_path_t p_rs = AISD_PATH_RECORD_SET;
   localparam aisd_path_t p_ix = AISD_PATH_DICT_INDEX;
   localparam aisd_path_t p_sx = AISD_PATH_SUBINDEX;
   logic clk_i, rst_b_i, adc_valid_i, module_fail_i, aux_missing_i, comm_err_i;
   logic [1:0] adc_ch_i;
   logic signed [15:0] adc_mv_i;
   logic rec_req_i, rec_write_i, rec_valid_o, rec_err_o, mod_led_o;
   aisd_path_t rec_path_i;
   logic [15:0] rec_key_i;
   logic [7:0] rec_sub_i, rec_wdata_i;
   logic [4:0] rec_byte_i, rec_len_o;
   aisd_byte_t rec_data_o;
   logic [3:0][15:0] chan_value_o;
   logic [3:0] chan_led_o;
   int n_fail, cmp_count, cyc, rel;

   aisd_diag_top DUT (.clk_i, .rst_b_i, .adc_valid_i, .adc_ch_i, .adc_mv_i, .module_fail_i,
      .aux_missing_i, .comm_err_i, .rec_req_i, .rec_write_i, .rec_path_i, .rec_key_i,
      .rec_sub_i, .rec_byte_i, .rec_wdata_i, .rec_valid_o, .rec_err_o, .rec_data_o,
      .rec_len_o, .chan_value_o, .chan_led_o, .mod_led_o);

   aisd_coupler u_cpl (.clk_i, .rec_valid_i(rec_valid_o), .rec_err_i(rec_err_o),
      .rec_data_i(rec_data_o), .rec_len_i(rec_len_o), .rec_req_o(rec_req_i),
      .rec_write_o(rec_write_i), .rec_path_o(rec_path_i), .rec_key_o(rec_key_i),
      .rec_sub_o(rec_sub_i), .rec_byte_o(rec_byte_i), .rec_wdata_o(rec_wdata_i));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic acc(input logic wr, input aisd_path_t p, input logic [15:0] k,
         input logic [7:0] s, input logic [4:0] b, input logic [7:0] wd, input logic [7:0] x,
         input logic [4:0] len, input logic err);
      logic v, e;
      logic [7:0] d;
      logic [4:0] l;
      u_cpl.xfer(wr, p, k, s, b, wd, v, e, d, l);
      chk({1'b0, v, e, l, d}, {2'b01, err, len, x});
   endtask : acc

   task automatic rd(input aisd_path_t p, input logic [15:0] k, input logic [7:0] s,
         input logic [4:0] b, input logic [7:0] x, input logic [4:0] len);
      acc(1'b0, p, k, s, b, 8'h00, x, len, 1'b0);
   endtask : rd

   task automatic rf(input logic [4:0] b, input logic [7:0] x);
      rd(p_rs, `AISD_RS_FULL, 8'h00, b, x, `AISD_LEN_FULL);
   endtask : rf

   task automatic bad(input logic wr, input aisd_path_t p, input logic [15:0] k,
         input logic [7:0] s, input logic [4:0] b);
      acc(wr, p, k, s, b, 8'h5A, 8'h00, 5'h00, 1'b1);
   endtask : bad

   task automatic wfn(input logic [1:0] ch, input logic [7:0] fn);
      acc(1'b1, p_rs, `AISD_RS_FN_BASE + 16'(ch), 8'h00, 5'h00, fn, 8'h00, `AISD_LEN_ONE, 1'b0);
   endtask : wfn

   task automatic sample(input logic [1:0] ch, input logic [15:0] mv);
      @(posedge clk_i);
      adc_valid_i <= 1'b1;
      adc_ch_i <= ch;
      adc_mv_i <= mv;
      @(posedge clk_i);
      adc_valid_i <= 1'b0;
      adc_mv_i <= ~mv;
      repeat (3) @(posedge clk_i);
      #1;
   endtask : sample

   task automatic t_defaults();
      logic [7:0] e [20];
      e = '{1: 8'h15, 4: 8'h71, 5: 8'h08, 6: 8'h04, default: 8'h00};
      for (int b = 0; b < 20; b++) begin
         rf(5'(b), e[b]);
      end
      for (int b = 0; b < 4; b++) begin
         rd(p_rs, `AISD_RS_SHORT, 8'h00, 5'(b), e[b], `AISD_LEN_SHORT);
      end
      for (int b = 0; b < 16; b++) begin
         rd(p_sx, `AISD_SX_INDEX, `AISD_SX_FIRST + 8'(b), 5'h00, e[b], `AISD_LEN_ONE);
      end
      bad(1'b0, p_rs, `AISD_RS_SHORT, 8'h00, 5'h04);
      rd(p_ix, `AISD_IX_FULL, 8'h00, 5'h06, 8'h04, `AISD_LEN_FULL);
      rd(p_ix, `AISD_IX_SHORT, 8'h00, 5'h01, 8'h15, `AISD_LEN_SHORT);
      rd(p_sx, `AISD_SX_INDEX, `AISD_SX_STAMP, 5'h03, 8'h00, `AISD_LEN_STAMP);
      bad(1'b0, p_sx, `AISD_SX_INDEX, 8'h12, 5'h00);
      bad(1'b0, AISD_PATH_NONE, `AISD_RS_FULL, 8'h00, 5'h00);
      bad(1'b1, p_rs, `AISD_RS_FULL, 8'h00, 5'h00);
   endtask : t_defaults

   task automatic t_faults();
      int c0;
      logic v, er;
      logic [7:0] d;
      logic [4:0] l;
      logic [31:0] st;
      @(posedge clk_i);
      c0 = cyc;
      module_fail_i <= 1'b1;
      aux_missing_i <= 1'b1;
      comm_err_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk(16'(mod_led_o), 16'h0001);
      rf(5'h00, 8'h13);
      rf(5'h03, 8'h10);
      for (int b = 0; b < 4; b++) begin
         u_cpl.xfer(1'b0, p_sx, `AISD_SX_INDEX, `AISD_SX_STAMP, 5'(b), 8'h00, v, er, d, l);
         st[8*b +: 8] = d;
      end
      chk(16'(st - 32'((c0 - rel) / 10) <= 32'd1), 16'h0001);
      module_fail_i <= 1'b0;
      aux_missing_i <= 1'b0;
      comm_err_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rf(5'h00, 8'h00);
   endtask : t_faults

   task automatic t_scale();
      logic [7:0] fn [4];
      logic [15:0] mv [5];
      logic [15:0] ev [4][5];
      logic [7:0] fl;
      fn = '{8'h12, 8'h10, 8'h22, 8'h20};
      mv = '{16'h2710, 16'h1388, 16'hD8F0, 16'hCD38, 16'h32C8};
      ev = '{'{16'h6C00, 16'h3600, 16'h9400, 16'h8100, 16'h7EFF},
         '{16'h6C00, 16'h3600, 16'hED00, 16'hED00, 16'h7EFF},
         '{16'h4000, 16'h2000, 16'hC000, 16'hB000, 16'h5000},
         '{16'h4000, 16'h2000, 16'hF333, 16'hF333, 16'h5000}};
      for (int i = 0; i < 4; i++) begin
         wfn(2'd0, fn[i]);
         for (int j = 0; j < 5; j++) begin
            fl = (j == 4) ? 8'h80 : (j == 3 || (j == 2 && !fn[i][1])) ? 8'h40 : 8'h00;
            sample(2'd0, mv[j]);
            chk(chan_value_o[0], ev[i][j]);
            rf(5'h08, fl);
         end
      end
      rf(5'h00, 8'h0C);
      rf(5'h07, 8'h01);
      chk(16'(chan_led_o), 16'h0001);
      wfn(2'd0, 8'h12);
      sample(2'd0, 16'h0000);
      rf(5'h08, 8'h00);
   endtask : t_scale

   task automatic t_off_cfg();
      wfn(2'd1, 8'hFF);
      sample(2'd1, 16'h32C8);
      chk(chan_value_o[1], 16'h0000);
      rf(5'h09, 8'h00);
      acc(1'b1, p_ix, `AISD_IX_FN_BASE + 16'h0002, 8'h00, 5'h00, 8'h33, 8'h00,
         `AISD_LEN_ONE, 1'b0);
      rd(p_rs, `AISD_RS_FN_BASE + 16'h0002, 8'h00, 5'h00, 8'h33, `AISD_LEN_ONE);
      rf(5'h0A, 8'h01);
      rf(5'h00, 8'h88);
      rf(5'h07, 8'h04);
      chk(16'(chan_led_o), 16'h0004);
      wfn(2'd2, 8'h12);
      rf(5'h00, 8'h00);
   endtask : t_off_cfg

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   initial begin
      rst_b_i = 1'b0;
      adc_valid_i = 1'b0;
      adc_ch_i = 2'd0;
      adc_mv_i = 16'h0000;
      module_fail_i = 1'b0;
      aux_missing_i = 1'b0;
      comm_err_i = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rel = cyc;
      t_defaults();
      t_faults();
      t_scale();
      t_off_cfg();
      end_sim();
   end
endmodule : tb_top
